// ===== rtl/csaf_consts.svh
`ifndef CSAF_CONSTS_SVH
`define CSAF_CONSTS_SVH

// Register byte addresses on the plain register port.
`define CSAF_ADDR_W 6
`define CSAF_REG_CTRL 6'h00
`define CSAF_REG_LL_LIM 6'h04
`define CSAF_REG_L_LIM 6'h08
`define CSAF_REG_H_LIM 6'h0C
`define CSAF_REG_HH_LIM 6'h10
`define CSAF_REG_RATE_LIM 6'h14
`define CSAF_REG_DEADBAND 6'h18
`define CSAF_REG_ABS_MIN 6'h1C
`define CSAF_REG_ABS_MAX 6'h20
`define CSAF_REG_FLAGS 6'h24
`define CSAF_REG_IRQ_STAT 6'h28
`define CSAF_REG_IRQ_MASK 6'h2C

// Control register field positions.
`define CSAF_CTRL_LATCH_BIT 0
`define CSAF_CTRL_UNLATCH_BIT 1
`define CSAF_CTRL_CAL_START_BIT 2
`define CSAF_CTRL_CAL_ABORT_BIT 3
`define CSAF_CTRL_CAL_DONE_BIT 4

// Absolute limits in microvolts for the +/-100 mV range (-101.00 mV and 101.00 mV).
`define CSAF_ABS_MIN_RST 32'hFFFE_7578
`define CSAF_ABS_MAX_RST 32'h0001_8A88

// Number of flag bits and interrupt status bits.
`define CSAF_NFLAGS 11
`define CSAF_NIRQ 8

`endif

// ===== rtl/csaf_pkg.sv
package csaf_pkg;

    // Channel status and alarm flags as presented to the controller.
    typedef struct packed {
        logic low_ref_bad_flag;
        logic low_ref_good_flag;
        logic calibrating;
        logic cal_fault_flag;
        logic rate_of_change_alarm;
        logic high_high_alarm;
        logic high_alarm;
        logic low_alarm;
        logic low_low_alarm;
        logic above_range;
        logic below_range;
    } csaf_flags_s;

    // Calibration sequencer states.
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_RUN
    } csaf_cal_e;

endpackage

// ===== rtl/csaf_channel.sv
`timescale 1ns/10ps
`include "csaf_consts.svh"

// Summary of operation
// R01: Below-range flag set while sample is under the absolute minimum.
// R02: Above-range flag set while sample is over the absolute maximum.
// R03: Low-low and low alarms raise when sample is below their limits.
// R04: High and high-high alarms raise when sample is above their limits.
// R05: Latched process alarms hold until unlatched or sample returns inside deadband.
// R06: Rate alarm raises when consecutive-sample difference exceeds the rate limit.
// R07: Latched rate alarm holds until explicitly unlatched, never self-clears.
// R08: Calibration fault flag set while uncalibrated or after a failed calibration.
// R09: A failure-set calibration fault clears at power-up reset.
// R10: Calibrating flag is one exactly while calibration runs.
// R11: Low-reference-good flag set once a valid low reference is sampled.
// R12: Low-reference-bad flag set on invalid reference; calibration cannot succeed then.
// R13: Abort with bad low reference sets fault until a later calibration succeeds.
// R14: Unlatched alarms follow their comparisons, re-evaluated on each new sample.
module csaf_channel
    import csaf_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [`CSAF_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic signed [DATA_W-1:0] sample_data,
    input wire logic low_ref_sampled,
    input wire logic low_ref_valid,
    output csaf_flags_s status_flags,
    output logic irq
);

    logic signed [DATA_W-1:0] ll_lim_r, l_lim_r, h_lim_r, hh_lim_r, abs_min_r, abs_max_r;
    logic [DATA_W-1:0] rate_lim_r, deadband_r;
    logic latch_en_r;
    logic signed [DATA_W-1:0] prev_r;
    logic have_prev_r;
    csaf_flags_s flags_r, flags_nxt;
    csaf_cal_e cal_r, cal_nxt;
    logic cal_ok_r, cal_ok_nxt;
    logic [`CSAF_NIRQ-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic wr_ctrl, unlatch, cal_start, cal_abort, cal_done;
    logic c_ll, c_l, c_h, c_hh, c_rate, in_db;
    logic signed [DATA_W:0] diff;
    logic [DATA_W:0] adiff;
    logic signed [DATA_W+1:0] smp_w, db_lo, db_hi;

    assign wr_ctrl = reg_write && (reg_addr == `CSAF_REG_CTRL);
    assign unlatch = wr_ctrl && reg_wdata[`CSAF_CTRL_UNLATCH_BIT];
    assign cal_start = wr_ctrl && reg_wdata[`CSAF_CTRL_CAL_START_BIT];
    assign cal_abort = wr_ctrl && reg_wdata[`CSAF_CTRL_CAL_ABORT_BIT];
    assign cal_done = wr_ctrl && reg_wdata[`CSAF_CTRL_CAL_DONE_BIT];

    // Trigger comparisons; the deadband window spans the low limit to the high limit, narrowed inward by the deadband.
    assign c_ll = sample_data < ll_lim_r; // R03
    assign c_l = sample_data < l_lim_r; // R03
    assign c_h = sample_data > h_lim_r; // R04
    assign c_hh = sample_data > hh_lim_r; // R04
    assign diff = {sample_data[DATA_W-1], sample_data} - {prev_r[DATA_W-1], prev_r};
    assign adiff = diff[DATA_W] ? DATA_W'(0) - diff : diff;
    assign c_rate = have_prev_r && (adiff > {1'b0, rate_lim_r}); // R06
    // Deadband edges are worked out two bits wider, so a large deadband cannot wrap around.
    assign smp_w = (DATA_W+2)'(sample_data);
    assign db_lo = (DATA_W+2)'(l_lim_r) + $signed((DATA_W+2)'(deadband_r));
    assign db_hi = (DATA_W+2)'(h_lim_r) - $signed((DATA_W+2)'(deadband_r));
    assign in_db = (smp_w >= db_lo) && (smp_w <= db_hi);

    // Limit and control registers; plain storage written by software.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ll_lim_r <= '0;
            l_lim_r <= '0;
            h_lim_r <= '0;
            hh_lim_r <= '0;
            rate_lim_r <= '0;
            deadband_r <= '0;
            abs_min_r <= DATA_W'(`CSAF_ABS_MIN_RST);
            abs_max_r <= DATA_W'(`CSAF_ABS_MAX_RST);
            latch_en_r <= 1'b0;
        end else if (reg_write) begin
            case (reg_addr)
                `CSAF_REG_CTRL: latch_en_r <= reg_wdata[`CSAF_CTRL_LATCH_BIT];
                `CSAF_REG_LL_LIM: ll_lim_r <= reg_wdata[DATA_W-1:0];
                `CSAF_REG_L_LIM: l_lim_r <= reg_wdata[DATA_W-1:0];
                `CSAF_REG_H_LIM: h_lim_r <= reg_wdata[DATA_W-1:0];
                `CSAF_REG_HH_LIM: hh_lim_r <= reg_wdata[DATA_W-1:0];
                `CSAF_REG_RATE_LIM: rate_lim_r <= reg_wdata[DATA_W-1:0];
                `CSAF_REG_DEADBAND: deadband_r <= reg_wdata[DATA_W-1:0];
                `CSAF_REG_ABS_MIN: abs_min_r <= reg_wdata[DATA_W-1:0];
                `CSAF_REG_ABS_MAX: abs_max_r <= reg_wdata[DATA_W-1:0];
                default: latch_en_r <= latch_en_r;
            endcase
        end
    end

    // Previous sample kept for the rate comparison; the first sample after reset never trips it.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prev_r <= '0;
            have_prev_r <= 1'b0;
        end else if (sample_valid) begin
            prev_r <= sample_data;
            have_prev_r <= 1'b1;
        end
    end

    // Next flag values; alarms only move on a new sample, or on unlatch.
    always_comb begin
        flags_nxt = flags_r;
        cal_nxt = cal_r;
        cal_ok_nxt = cal_ok_r;
        if (sample_valid) begin
            flags_nxt.below_range = sample_data < abs_min_r; // R01
            flags_nxt.above_range = sample_data > abs_max_r; // R02
            if (latch_en_r) begin
                // A latched process alarm drops once the sample is back inside the deadband.
                flags_nxt.low_low_alarm = c_ll || (flags_r.low_low_alarm && !in_db); // R05
                flags_nxt.low_alarm = c_l || (flags_r.low_alarm && !in_db); // R05
                flags_nxt.high_alarm = c_h || (flags_r.high_alarm && !in_db); // R05
                flags_nxt.high_high_alarm = c_hh || (flags_r.high_high_alarm && !in_db); // R05
                flags_nxt.rate_of_change_alarm = c_rate || flags_r.rate_of_change_alarm; // R07
            end else begin
                flags_nxt.low_low_alarm = c_ll; // R14
                flags_nxt.low_alarm = c_l; // R14
                flags_nxt.high_alarm = c_h; // R14
                flags_nxt.high_high_alarm = c_hh; // R14
                flags_nxt.rate_of_change_alarm = c_rate; // R14
            end
        end
        // Unlatch clears held alarms only in latched mode; a trigger in the same sample still wins.
        if (unlatch && latch_en_r && !sample_valid) begin
            flags_nxt.low_low_alarm = 1'b0; // R05
            flags_nxt.low_alarm = 1'b0;
            flags_nxt.high_alarm = 1'b0;
            flags_nxt.high_high_alarm = 1'b0;
            flags_nxt.rate_of_change_alarm = 1'b0; // R07
        end else if (unlatch && latch_en_r) begin
            flags_nxt.low_low_alarm = c_ll;
            flags_nxt.low_alarm = c_l;
            flags_nxt.high_alarm = c_h;
            flags_nxt.high_high_alarm = c_hh;
            flags_nxt.rate_of_change_alarm = c_rate;
        end
        // Calibration sequencer for the low-reference step.
        case (cal_r)
            CAL_IDLE: begin
                if (cal_start) begin
                    cal_nxt = CAL_RUN;
                    cal_ok_nxt = 1'b0;
                    flags_nxt.low_ref_good_flag = 1'b0;
                    flags_nxt.low_ref_bad_flag = 1'b0;
                end
            end
            CAL_RUN: begin
                if (low_ref_sampled) begin
                    flags_nxt.low_ref_good_flag = low_ref_valid; // R11
                    flags_nxt.low_ref_bad_flag = !low_ref_valid; // R12
                end
                if (cal_abort) begin
                    cal_nxt = CAL_IDLE;
                end else if (cal_done && flags_r.low_ref_good_flag && !flags_r.low_ref_bad_flag) begin
                    cal_nxt = CAL_IDLE; // R12
                    cal_ok_nxt = 1'b1; // R13
                end
            end
            default: cal_nxt = CAL_IDLE;
        endcase
        flags_nxt.calibrating = (cal_nxt == CAL_RUN); // R10
        // A run discards the old calibration, so the fault stands until a run succeeds or power-up.
        flags_nxt.cal_fault_flag = !cal_ok_nxt; // R08 R13
    end

    // Interrupt status: sticky, write-one-to-clear, and a new event wins over the clear.
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        if (reg_write && reg_addr == `CSAF_REG_IRQ_STAT) begin
            irq_stat_nxt = irq_stat_r & ~reg_wdata[`CSAF_NIRQ-1:0];
        end
        if (reg_write && reg_addr == `CSAF_REG_IRQ_MASK) begin
            irq_mask_nxt = reg_wdata[`CSAF_NIRQ-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | (flags_nxt[`CSAF_NIRQ-1:0] & ~flags_r[`CSAF_NIRQ-1:0]);
    end

    // Read data for the cycle after a read strobe; unmapped addresses read zero.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_read) begin
            case (reg_addr)
                `CSAF_REG_CTRL: rdata_nxt = {31'h0000_0000, latch_en_r};
                `CSAF_REG_LL_LIM: rdata_nxt = 32'(ll_lim_r);
                `CSAF_REG_L_LIM: rdata_nxt = 32'(l_lim_r);
                `CSAF_REG_H_LIM: rdata_nxt = 32'(h_lim_r);
                `CSAF_REG_HH_LIM: rdata_nxt = 32'(hh_lim_r);
                `CSAF_REG_RATE_LIM: rdata_nxt = 32'(rate_lim_r);
                `CSAF_REG_DEADBAND: rdata_nxt = 32'(deadband_r);
                `CSAF_REG_ABS_MIN: rdata_nxt = 32'(abs_min_r);
                `CSAF_REG_ABS_MAX: rdata_nxt = 32'(abs_max_r);
                `CSAF_REG_FLAGS: rdata_nxt = 32'(flags_r);
                `CSAF_REG_IRQ_STAT: rdata_nxt = 32'(irq_stat_r);
                `CSAF_REG_IRQ_MASK: rdata_nxt = 32'(irq_mask_r);
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // State registers; reset is power-up, which also clears a failure-set fault marker.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flags_r <= '0;
            cal_r <= CAL_IDLE;
            cal_ok_r <= 1'b1; // R09
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            rdata_r <= 32'h0000_0000;
        end else begin
            flags_r <= flags_nxt;
            cal_r <= cal_nxt;
            cal_ok_r <= cal_ok_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign status_flags = flags_r;
    assign reg_rdata = rdata_r;
    assign irq = |(irq_stat_r & irq_mask_r);

    // Sequence for the latched rate-alarm behaviour.
    sequence s_rate_latched;
        latch_en_r && flags_r.rate_of_change_alarm && !unlatch;
    endsequence

    // Sequence for a running calibration with a bad reference and no abort, where any done request must be refused.
    sequence s_cal_refused;
        cal_r == CAL_RUN && flags_r.low_ref_bad_flag && !cal_abort;
    endsequence

    a_below_range_cmp: assert property (@(posedge core_clk) disable iff (reset) // R01
        sample_valid |=> status_flags.below_range == ($past(sample_data) < $past(abs_min_r)))
        else $error("below range flag wrong");
    a_above_range_cmp: assert property (@(posedge core_clk) disable iff (reset) // R02
        sample_valid |=> status_flags.above_range == ($past(sample_data) > $past(abs_max_r)))
        else $error("above range flag wrong");
    a_low_alarm_set: assert property (@(posedge core_clk) disable iff (reset) // R03
        (sample_valid && c_ll) |=> status_flags.low_low_alarm && status_flags.low_alarm ||
            !$past(c_l) && status_flags.low_low_alarm)
        else $error("low alarm not raised");
    a_high_alarm_set: assert property (@(posedge core_clk) disable iff (reset) // R04
        (sample_valid && c_hh) |=> status_flags.high_high_alarm)
        else $error("high high alarm not raised");
    a_proc_latch_hold: assert property (@(posedge core_clk) disable iff (reset) // R05
        (latch_en_r && flags_r.low_alarm && sample_valid && !in_db && !unlatch) |=> status_flags.low_alarm)
        else $error("latched low alarm dropped");
    a_rate_alarm_set: assert property (@(posedge core_clk) disable iff (reset) // R06
        (sample_valid && c_rate) |=> status_flags.rate_of_change_alarm)
        else $error("rate alarm not raised");
    a_rate_latch_hold: assert property (@(posedge core_clk) disable iff (reset) // R07
        s_rate_latched |=> status_flags.rate_of_change_alarm)
        else $error("latched rate alarm dropped");
    a_cal_flag_track: assert property (@(posedge core_clk) disable iff (reset) // R10
        (cal_r == CAL_IDLE && cal_start) |=> status_flags.calibrating && status_flags.cal_fault_flag)
        else $error("calibration did not start");
    a_abort_fault_set: assert property (@(posedge core_clk) disable iff (reset) // R13
        (cal_r == CAL_RUN && cal_abort && !cal_ok_r) |=> status_flags.cal_fault_flag[*2])
        else $error("abort did not hold fault");
    a_unlatched_follow: assert property (@(posedge core_clk) disable iff (reset) // R14
        (sample_valid && !latch_en_r && !c_h) |=> !status_flags.high_alarm)
        else $error("unlatched alarm not following");

    // Further checks on single alarms, the first sample, the reference step and power-up.
    a_high_alarm_raise: assert property (@(posedge core_clk) disable iff (reset) // R04
        (sample_valid && c_h) |=> status_flags.high_alarm)
        else $error("high alarm not raised");
    a_ll_latch_hold: assert property (@(posedge core_clk) disable iff (reset) // R05
        (latch_en_r && flags_r.low_low_alarm && sample_valid && !in_db && !unlatch) |=> status_flags.low_low_alarm)
        else $error("latched low low alarm dropped");
    a_rate_first_quiet: assert property (@(posedge core_clk) disable iff (reset) // R06
        (sample_valid && !have_prev_r && !latch_en_r) |=> !status_flags.rate_of_change_alarm)
        else $error("rate alarm on first sample");
    a_ref_good_set: assert property (@(posedge core_clk) disable iff (reset) // R11
        (cal_r == CAL_RUN && low_ref_sampled && low_ref_valid) |=> status_flags.low_ref_good_flag)
        else $error("good reference flag not set");
    a_ref_bad_set: assert property (@(posedge core_clk) disable iff (reset) // R12
        (cal_r == CAL_RUN && low_ref_sampled && !low_ref_valid) |=> status_flags.low_ref_bad_flag)
        else $error("bad reference flag not set");
    a_done_refused: assert property (@(posedge core_clk) disable iff (reset) // R12
        s_cal_refused |=> status_flags.calibrating)
        else $error("calibration ended with bad reference");
    a_cal_leave: assert property (@(posedge core_clk) disable iff (reset) // R10
        (cal_r == CAL_RUN && cal_abort) |=> !status_flags.calibrating)
        else $error("abort did not end calibration");
    a_fault_after_reset: assert property (@(posedge core_clk) // R09
        reset |=> !status_flags.cal_fault_flag)
        else $error("fault flag not cleared by power-up");

endmodule

// ===== verification/csaf_src_model.sv
`timescale 1ns/10ps

// Sample and reference source in front of the channel. Between pulses the data lines show the
// inverse of the last value, so a design that samples outside the strobe sees wrong data.
module csaf_src_model #(
    parameter int DATA_W = 32
) (
    input wire logic core_clk,
    output logic sample_valid,
    output logic signed [DATA_W-1:0] sample_data,
    output logic low_ref_sampled,
    output logic low_ref_valid
);
    initial begin
        sample_valid = 1'b0;
        sample_data = '0;
        low_ref_sampled = 1'b0;
        low_ref_valid = 1'b0;
    end

    // One-cycle sample pulse; returns at the edge that takes it.
    task automatic send_sample(input logic signed [DATA_W-1:0] d);
        @(posedge core_clk);
        sample_valid <= 1'b1;
        sample_data <= d;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        sample_data <= ~d;
    endtask

    // One-cycle low reference pulse with its quality bit.
    task automatic send_ref(input logic v);
        @(posedge core_clk);
        low_ref_sampled <= 1'b1;
        low_ref_valid <= v;
        @(posedge core_clk);
        low_ref_sampled <= 1'b0;
        low_ref_valid <= ~v;
    endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/10ps
`include "csaf_consts.svh"

module tb
    import csaf_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [`CSAF_ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic sample_valid;
    logic signed [31:0] sample_data;
    logic low_ref_sampled;
    logic low_ref_valid;
    csaf_flags_s status_flags;
    logic irq;
    int n_fail = 0;
    int checks_done = 0;

    // The clock period is 100 ns.
    always #50 core_clk = ~core_clk;

    csaf_channel DUT (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .sample_data(sample_data), .low_ref_sampled(low_ref_sampled), .low_ref_valid(low_ref_valid),
        .status_flags(status_flags), .irq(irq));

    csaf_src_model src (.core_clk(core_clk), .sample_valid(sample_valid), .sample_data(sample_data),
        .low_ref_sampled(low_ref_sampled), .low_ref_valid(low_ref_valid));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A write is taken at the edge that ends its cycle; one more edge lets its effects land.
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // Read data stand only in the cycle after the strobe, so they are looked at in that cycle.
    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string name);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        chk(name, reg_rdata, exp);
    endtask

    // Sends one sample and compares the seven range and alarm flags.
    task automatic smp(input logic signed [31:0] d, input logic [6:0] e);
        src.send_sample(d);
        @(negedge core_clk);
        chk("alarm flags", {25'h0, status_flags[6:0]}, {25'h0, e});
    endtask

    task automatic t_reset();
        chk("flags at reset", {21'h0, status_flags}, 32'h0000_0000);
        chk("irq at reset", {31'h0, irq}, 32'h0);
        rd(`CSAF_REG_ABS_MIN, `CSAF_ABS_MIN_RST, "abs min");
        rd(`CSAF_REG_ABS_MAX, `CSAF_ABS_MAX_RST, "abs max");
        rd(6'h30, 32'h0, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_limits();
        logic signed [31:0] d[11] = '{-102000, 102000, -101000, 101000, -60, -30, 0, 30, 60, -50, 50};
        logic [6:0] e[11] = '{7'h0D, 7'h32, 7'h0C, 7'h30, 7'h0C, 7'h08, 7'h00, 7'h10, 7'h30, 7'h08, 7'h10};
        wr(`CSAF_REG_LL_LIM, -32'sd50);
        wr(`CSAF_REG_L_LIM, -32'sd20);
        wr(`CSAF_REG_H_LIM, 32'h0000_0014);
        wr(`CSAF_REG_HH_LIM, 32'h0000_0032);
        wr(`CSAF_REG_RATE_LIM, 32'h7FFF_FFFF);
        // Boundary values sit exactly on the low-low, high-high and absolute limits, where the comparison is strict.
        for (int i = 0; i < 11; i++) begin
            smp(d[i], e[i]);
        end
        $display("test limits done");
    endtask

    task automatic t_latch();
        wr(`CSAF_REG_DEADBAND, 32'h0000_0005);
        wr(`CSAF_REG_CTRL, 32'h0000_0001);
        smp(60, 7'h30);
        smp(30, 7'h30);
        smp(16, 7'h30);
        smp(15, 7'h00);
        smp(-60, 7'h0C);
        wr(`CSAF_REG_CTRL, 32'h0000_0003);
        chk("flags after unlatch", {25'h0, status_flags[6:0]}, 32'h0);
        $display("test latch done");
    endtask

    task automatic t_rate();
        wr(`CSAF_REG_CTRL, 32'h0000_0000);
        wr(`CSAF_REG_RATE_LIM, 32'h0000_000A);
        smp(0, 7'h40);
        smp(10, 7'h00);
        smp(-1, 7'h40);
        smp(-1, 7'h00);
        wr(`CSAF_REG_CTRL, 32'h0000_0001);
        smp(10, 7'h40);
        smp(10, 7'h40);
        wr(`CSAF_REG_CTRL, 32'h0000_0003);
        chk("rate after unlatch", {31'h0, status_flags.rate_of_change_alarm}, 32'h0);
        wr(`CSAF_REG_CTRL, 32'h0000_0000);
        $display("test rate done");
    endtask

    task automatic t_irq();
        wr(`CSAF_REG_IRQ_MASK, 32'h0000_0000);
        wr(`CSAF_REG_IRQ_STAT, 32'h0000_00FF);
        rd(`CSAF_REG_IRQ_STAT, 32'h0, "status cleared");
        wr(`CSAF_REG_IRQ_MASK, 32'h0000_0001);
        chk("irq idle", {31'h0, irq}, 32'h0);
        smp(-102000, 7'h4D);
        chk("irq raised", {31'h0, irq}, 32'h1);
        rd(`CSAF_REG_IRQ_STAT, 32'h0000_004D, "status events");
        wr(`CSAF_REG_IRQ_MASK, 32'h0000_0000);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`CSAF_REG_IRQ_MASK, 32'h0000_0001);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(`CSAF_REG_IRQ_STAT, 32'h0000_0001);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rd(`CSAF_REG_IRQ_STAT, 32'h0000_004C, "status after clear");
        $display("test irq done");
    endtask

    // Calibration flags are compared as bits 10 down to 7: bad, good, calibrating, fault.
    task automatic t_cal();
        wr(`CSAF_REG_CTRL, 32'h0000_0004);
        chk("cal start", {28'h0, status_flags[10:7]}, 32'h3);
        src.send_ref(1'b0);
        @(negedge core_clk);
        chk("bad reference", {28'h0, status_flags[10:7]}, 32'hB);
        wr(`CSAF_REG_CTRL, 32'h0000_0010);
        chk("done refused", {28'h0, status_flags[10:7]}, 32'hB);
        wr(`CSAF_REG_CTRL, 32'h0000_0008);
        chk("abort", {30'h0, status_flags[8:7]}, 32'h1);
        // A power-up reset after the failed run clears the fault and the reference flags.
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        chk("fault after reset", {28'h0, status_flags[10:7]}, 32'h0);
        wr(`CSAF_REG_CTRL, 32'h0000_0004);
        src.send_ref(1'b1);
        @(negedge core_clk);
        chk("good reference", {29'h0, status_flags[9:7]}, 32'h7);
        wr(`CSAF_REG_CTRL, 32'h0000_0010);
        chk("cal done", {30'h0, status_flags[8:7]}, 32'h0);
        $display("test calibration done");
    endtask

    // Watchdog: a hang counts as a mismatch and ends the run.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_limits();
        t_latch();
        t_rate();
        t_irq();
        t_cal();
        finish_test();
    end
endmodule
